// file: rtl/udws_regs.svh
// Shared constants of the dispatch and writeback scheduler
`ifndef UDWS_REGS_SVH
`define UDWS_REGS_SVH
`define UDWS_ISSUE_PORTS 6
`define UDWS_RENAME_WIDTH 4
`define UDWS_STACKS 3
`define UDWS_SRCS 2
`define UDWS_WB_DEPTH 8
`define UDWS_LOAD_LAT 3'h4
`define UDWS_XFER_PORT_A 0
`define UDWS_XFER_PORT_B 5
`endif

// file: rtl/udws_pkg.sv
// Types of the dispatch and writeback scheduler
package udws_pkg;
  typedef enum logic [1:0] {
    DOM_INT = 2'h0,
    DOM_VINT = 2'h1,
    DOM_VFP = 2'h2,
    DOM_LEGACY = 2'h3
  } udws_dom_t;
  typedef enum logic [1:0] {
    STK_INT = 2'h0,
    STK_VEC = 2'h1,
    STK_LEGACY = 2'h2
  } udws_stack_t;
  typedef enum logic [4:0] {
    CLS_ALU = 5'h00,
    CLS_SHIFT = 5'h01,
    CLS_ADDR_FAST = 5'h02,
    CLS_ADDR_SLOW = 5'h03,
    CLS_MUL = 5'h04,
    CLS_BRANCH = 5'h05,
    CLS_LD_ADDR = 5'h06,
    CLS_ST_ADDR = 5'h07,
    CLS_ST_DATA = 5'h08,
    CLS_DIV = 5'h09,
    CLS_STR_CMP = 5'h0a,
    CLS_MOV128 = 5'h0b,
    CLS_SHUF = 5'h0c,
    CLS_BLEND = 5'h0d,
    CLS_ADD = 5'h0e,
    CLS_CVT = 5'h0f,
    CLS_MOV256 = 5'h10
  } udws_cls_t;
endpackage

// file: rtl/udws_oldest_pick.sv
// Oldest-first selector over a circular age order starting at the head
`timescale 1ns/1ps
module udws_oldest_pick #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,
  input wire logic [$clog2(N)-1:0] head,
  output logic gnt_vld,
  output logic [$clog2(N)-1:0] gnt_idx
);
  localparam int IW = $clog2(N);

  // Walk from youngest to oldest so the last hit is the oldest
  always_comb begin
    logic [IW-1:0] idx;
    idx = '0;
    gnt_vld = 1'b0;
    gnt_idx = head;
    for (int k = N - 1; k >= 0; k--) begin
      idx = head + IW'(k);
      if (req[idx]) begin
        gnt_vld = 1'b1;
        gnt_idx = idx;
      end
    end
  end
endmodule

// file: rtl/udws_wb_resv.sv
// Writeback reservation record of one dispatch port, one lane per stack
`timescale 1ns/1ps
`include "udws_regs.svh"
module udws_wb_resv #(
  parameter int TW = 6
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic put_valid,
  input wire logic [1:0] put_stack,
  input wire logic [2:0] put_lat,
  input wire logic [TW-1:0] put_tag,
  output logic [`UDWS_STACKS-1:0][`UDWS_WB_DEPTH-1:0] busy,
  output logic [`UDWS_STACKS-1:0] wb_valid_reg,
  output logic [`UDWS_STACKS-1:0][TW-1:0] wb_tag_reg
);
  localparam int S = `UDWS_STACKS;
  localparam int D = `UDWS_WB_DEPTH;
  logic [S-1:0][D-1:0] slot_reg;
  logic [S-1:0][D-1:0][TW-1:0] stag_reg;

  assign busy = slot_reg;

  // Slot k holds a result due k+1 cycles later; lanes of other stacks never clash
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slot_reg <= '0;
      stag_reg <= '0;
    end else begin
      for (int s = 0; s < S; s++) begin
        for (int k = 0; k < D; k++) begin
          if (put_valid && put_stack == 2'(s) && put_lat == 3'(k + 1)) begin
            slot_reg[s][k] <= 1'b1;
            stag_reg[s][k] <= put_tag;
          end else begin
            slot_reg[s][k] <= (k == D - 1) ? 1'b0 : slot_reg[s][(k + 1) % D];
            stag_reg[s][k] <= stag_reg[s][(k + 1) % D];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_valid_reg <= '0;
      wb_tag_reg <= '0;
    end else begin
      for (int s = 0; s < S; s++) begin
        wb_valid_reg[s] <= slot_reg[s][0];
        wb_tag_reg[s] <= stag_reg[s][0];
      end
    end
  end

  a_wb_no_clash: assert property (@(posedge clk_sys) disable iff (!nrst)
    put_valid |-> !slot_reg[put_stack][put_lat])
    else $error("writeback slot claimed twice");
  a_wb_lat_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    put_valid && put_lat == 3'h1 |-> ##2 wb_valid_reg[$past(put_stack, 2)])
    else $error("one-cycle result missed its bus");
  a_wb_lat_five: assert property (@(posedge clk_sys) disable iff (!nrst)
    put_valid && put_lat == 3'h5 |-> ##6 wb_valid_reg[$past(put_stack, 6)])
    else $error("five-cycle result missed its bus");
endmodule

// file: rtl/udws_scheduler.sv
// Out-of-order scheduler: wakeup, six-port dispatch and writeback arbitration
// Notes on behaviour
// - At most six micro-ops issue per cycle, one per dispatch port.
// - Selection weighs free ports, free writeback buses and age priority.
// - Each issued source is marked as register-file read or bypass.
// - Integer classes follow the fixed port table for ports 0 to 5.
// - Vector integer port 0: multiply, shift, text compare, divide, 128-bit move.
// - Vector integer port 1 and port 5 classes follow the table.
// - Float classes: port 0 multiply/divide, port 1 add/convert, port 5 shuffle.
// - Results return on the bus of their port and result stack.
// - Same port and stack bus clash holds the later micro-op back.
// - Different stacks on one port never clash on writeback.
// - Three stacks: integer, vector, legacy float, each with own bus.
// - Load data is written into the stack of the load's destination.
// - Cross-stack sources cost extra cycles or an inserted transfer micro-op, except vector integer to or from legacy.
// - Integer to vector needs a port 0 transfer; legacy adds a cycle.
// - Vector to integer needs a port 5 transfer; legacy adds a cycle.
// - Vector int/float cost one cycle; float to legacy uses port 5 plus one.
// - Loads forward: integer zero, vector one, legacy two cycles.
// - Micro-ops wait until all sources are ready, then go oldest first.
`timescale 1ns/1ps
`include "udws_regs.svh"
module udws_scheduler #(
  parameter int N = 16,
  parameter int TW = 6
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`UDWS_RENAME_WIDTH-1:0] in_valid,
  input wire logic [`UDWS_RENAME_WIDTH-1:0][TW-1:0] in_tag,
  input wire logic [`UDWS_RENAME_WIDTH-1:0][4:0] in_cls,
  input wire logic [`UDWS_RENAME_WIDTH-1:0][1:0] in_dom,
  input wire logic [`UDWS_RENAME_WIDTH-1:0][2:0] in_lat,
  input wire logic [`UDWS_RENAME_WIDTH-1:0][`UDWS_SRCS-1:0][TW-1:0] in_src_tag,
  input wire logic [`UDWS_RENAME_WIDTH-1:0][`UDWS_SRCS-1:0] in_src_rdy,
  output logic alloc_ready_reg,
  output logic [`UDWS_ISSUE_PORTS-1:0] iss_valid_reg,
  output logic [`UDWS_ISSUE_PORTS-1:0][TW-1:0] iss_tag_reg,
  output logic [`UDWS_ISSUE_PORTS-1:0][`UDWS_SRCS-1:0] iss_byp_reg,
  output logic [1:0] xfer_valid_reg,
  output logic [`UDWS_ISSUE_PORTS-1:0][`UDWS_STACKS-1:0] wb_valid_reg,
  output logic [`UDWS_ISSUE_PORTS-1:0][`UDWS_STACKS-1:0][TW-1:0] wb_tag_reg
);
  localparam int IW = $clog2(N);
  localparam int P = `UDWS_ISSUE_PORTS;
  localparam int R = `UDWS_RENAME_WIDTH;
  localparam int S = `UDWS_STACKS;
  localparam int NS = `UDWS_SRCS;
  localparam int D = `UDWS_WB_DEPTH;

  // Power-of-two ring so pointer wrap is free; at least two rename groups deep
  if (N < 2 * R || (N & (N - 1)) != 0) begin : g_bad_depth
    $error("udws_scheduler: N must be a power of two of at least 8");
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [P-1:0] port_mask(logic [4:0] c, logic [1:0] d);
    port_mask = 6'h00;
    if (c == udws_pkg::CLS_ST_DATA) port_mask = 6'h10;
    else if (c == udws_pkg::CLS_LD_ADDR || c == udws_pkg::CLS_ST_ADDR) port_mask = 6'h0c;
    else if (d == udws_pkg::DOM_INT) begin
      unique case (c)
        udws_pkg::CLS_ALU: port_mask = 6'h23;
        udws_pkg::CLS_SHIFT: port_mask = 6'h21;
        udws_pkg::CLS_ADDR_FAST: port_mask = 6'h22;
        udws_pkg::CLS_ADDR_SLOW, udws_pkg::CLS_MUL: port_mask = 6'h02;
        udws_pkg::CLS_BRANCH: port_mask = 6'h20;
        default: port_mask = 6'h00;
      endcase
    end else if (d == udws_pkg::DOM_VINT) begin
      unique case (c)
        udws_pkg::CLS_MUL, udws_pkg::CLS_STR_CMP, udws_pkg::CLS_DIV: port_mask = 6'h01;
        udws_pkg::CLS_SHIFT: port_mask = 6'h21;
        udws_pkg::CLS_ALU, udws_pkg::CLS_SHUF, udws_pkg::CLS_BLEND: port_mask = 6'h22;
        udws_pkg::CLS_MOV128: port_mask = 6'h23;
        default: port_mask = 6'h00;
      endcase
    end else begin
      unique case (c)
        udws_pkg::CLS_MUL, udws_pkg::CLS_DIV: port_mask = 6'h01;
        udws_pkg::CLS_BLEND, udws_pkg::CLS_MOV256: port_mask = 6'h21;
        udws_pkg::CLS_ADD, udws_pkg::CLS_CVT: port_mask = 6'h02;
        udws_pkg::CLS_SHUF: port_mask = 6'h20;
        default: port_mask = 6'h00;
      endcase
    end
  endfunction

  // Vector integer and low-half float share one stack and one bus
  function automatic logic [1:0] dom_stack(logic [1:0] d);
    unique case (d)
      udws_pkg::DOM_INT: dom_stack = udws_pkg::STK_INT;
      udws_pkg::DOM_LEGACY: dom_stack = udws_pkg::STK_LEGACY;
      default: dom_stack = udws_pkg::STK_VEC;
    endcase
  endfunction

  function automatic logic has_wb(logic [4:0] c);
    has_wb = !(c == udws_pkg::CLS_ST_ADDR || c == udws_pkg::CLS_ST_DATA || c == udws_pkg::CLS_BRANCH);
  endfunction

  function automatic logic [2:0] eff_lat(logic [4:0] c, logic [2:0] l);
    eff_lat = (c == udws_pkg::CLS_LD_ADDR) ? `UDWS_LOAD_LAT : l;
  endfunction

  // {transfer needed, transfer on port 5, extra cycles including the transfer}
  function automatic logic [4:0] fwd_cost(logic [1:0] pd, logic pl, logic [1:0] cd);
    if (pl) begin
      unique case (cd)
        udws_pkg::DOM_INT: fwd_cost = 5'h00;
        udws_pkg::DOM_LEGACY: fwd_cost = 5'h02;
        default: fwd_cost = 5'h01;
      endcase
    end else if (pd == cd) fwd_cost = 5'h00;
    else begin
      unique case ({pd, cd})
        4'h1, 4'h2: fwd_cost = 5'h11;
        4'h3: fwd_cost = 5'h12;
        4'h4, 4'h8: fwd_cost = 5'h19;
        4'h6, 4'h9: fwd_cost = 5'h01;
        4'h7, 4'hd: fwd_cost = 5'h00;
        4'hb, 4'he: fwd_cost = 5'h1a;
        default: fwd_cost = 5'h1a;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Entry state
  // ----------------------------------------------------------------
  logic [N-1:0] e_vld_reg;
  logic [N-1:0][TW-1:0] e_tag_reg;
  logic [N-1:0][4:0] e_cls_reg;
  logic [N-1:0][1:0] e_dom_reg;
  logic [N-1:0][2:0] e_lat_reg;
  logic [N-1:0][NS-1:0] s_rdy_reg;
  logic [N-1:0][NS-1:0][TW-1:0] s_tag_reg;
  logic [N-1:0][NS-1:0][3:0] s_cnt_reg;
  logic [IW-1:0] head_reg;
  logic [IW-1:0] tail_reg;

  logic [N-1:0] e_rdy;
  logic [N-1:0][NS-1:0] s_fresh;
  logic [P-1:0][S-1:0][D-1:0] busy;
  logic [P-1:0][N-1:0] req;
  logic [P:0][N-1:0] taken;
  logic [P-1:0] sel_vld;
  logic [P-1:0][IW-1:0] sel_idx;
  logic [P-1:0] bc_vld;
  logic [N-1:0] issued;
  logic [N-1:0] a_vld;
  logic [N-1:0][1:0] a_src;
  logic [N-1:0][NS-1:0][6:0] wk;
  logic [1:0] xfer_next;
  logic [N-1:0] vld_next;
  logic [IW-1:0] tail_next;
  logic [IW-1:0] head_next;
  logic alloc_ready_next;

  // ----------------------------------------------------------------
  // Readiness and selection
  // ----------------------------------------------------------------
  // A source whose countdown ends this cycle is taken from the bypass network
  always_comb begin
    for (int i = 0; i < N; i++) begin
      for (int k = 0; k < NS; k++) begin
        s_fresh[i][k] = !s_rdy_reg[i][k] && s_cnt_reg[i][k] == 4'h1;
      end
      e_rdy[i] = e_vld_reg[i] && &(s_rdy_reg[i] | s_fresh[i]);
    end
  end

  assign taken[0] = '0;
  for (genvar p = 0; p < P; p++) begin : g_port
    always_comb begin
      for (int i = 0; i < N; i++) begin
        req[p][i] = e_rdy[i] && |(port_mask(e_cls_reg[i], e_dom_reg[i]) & (P'(1) << p))
          && !taken[p][i]
          && !(has_wb(e_cls_reg[i])
            && busy[p][dom_stack(e_dom_reg[i])][eff_lat(e_cls_reg[i], e_lat_reg[i])]);
      end
      // A transfer micro-op owns its port for the cycle
      if ((p == `UDWS_XFER_PORT_A && xfer_valid_reg[0]) || (p == `UDWS_XFER_PORT_B && xfer_valid_reg[1])) begin
        req[p] = '0;
      end
    end
    udws_oldest_pick #(.N(N)) u_pick (
      .req(req[p]),
      .head(head_reg),
      .gnt_vld(sel_vld[p]),
      .gnt_idx(sel_idx[p])
    );
    assign taken[p+1] = taken[p] | (sel_vld[p] ? (N'(1) << sel_idx[p]) : N'(0));
    assign bc_vld[p] = sel_vld[p] && has_wb(e_cls_reg[sel_idx[p]]);
    udws_wb_resv #(.TW(TW)) u_resv (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .put_valid(bc_vld[p]),
      .put_stack(dom_stack(e_dom_reg[sel_idx[p]])),
      .put_lat(eff_lat(e_cls_reg[sel_idx[p]], e_lat_reg[sel_idx[p]])),
      .put_tag(e_tag_reg[sel_idx[p]]),
      .busy(busy[p]),
      .wb_valid_reg(wb_valid_reg[p]),
      .wb_tag_reg(wb_tag_reg[p])
    );
  end
  assign issued = taken[P];

  // ----------------------------------------------------------------
  // Wakeup and allocation
  // ----------------------------------------------------------------
  // Issue broadcasts start each consumer's countdown at latency plus crossing cost
  function automatic logic [6:0] wake(logic [TW-1:0] t, logic [1:0] cd, logic [P-1:0] bv,
                                      logic [P-1:0][IW-1:0] bi, logic [N-1:0][TW-1:0] et,
                                      logic [N-1:0][4:0] ec, logic [N-1:0][1:0] ed,
                                      logic [N-1:0][2:0] el);
    logic [4:0] c;
    c = 5'h00;
    wake = 7'h00;
    for (int p = 0; p < P; p++) begin
      if (bv[p] && et[bi[p]] == t) begin
        c = fwd_cost(ed[bi[p]], ec[bi[p]] == udws_pkg::CLS_LD_ADDR, cd);
        wake = {1'b1, c[4:3], 4'(eff_lat(ec[bi[p]], el[bi[p]])) + 4'(c[2:0])};
      end
    end
  endfunction

  always_comb begin
    a_vld = '0;
    a_src = '0;
    xfer_next = 2'h0;
    for (int j = 0; j < R; j++) begin
      if (alloc_ready_reg && in_valid[j]) begin
        a_vld[tail_reg + IW'(j)] = 1'b1;
        a_src[tail_reg + IW'(j)] = 2'(j);
      end
    end
    for (int i = 0; i < N; i++) begin
      for (int k = 0; k < NS; k++) begin
        if (a_vld[i]) begin
          wk[i][k] = in_src_rdy[a_src[i]][k] ? 7'h00 : wake(in_src_tag[a_src[i]][k], in_dom[a_src[i]],
            bc_vld, sel_idx, e_tag_reg, e_cls_reg, e_dom_reg, e_lat_reg);
        end else if (e_vld_reg[i] && !s_rdy_reg[i][k] && s_cnt_reg[i][k] == 4'h0) begin
          wk[i][k] = wake(s_tag_reg[i][k], e_dom_reg[i], bc_vld, sel_idx, e_tag_reg, e_cls_reg,
            e_dom_reg, e_lat_reg);
        end else begin
          wk[i][k] = 7'h00;
        end
        if (wk[i][k][6] && wk[i][k][5]) begin
          xfer_next[wk[i][k][4]] = 1'b1;
        end
      end
    end
    vld_next = (e_vld_reg & ~issued) | a_vld;
    tail_next = tail_reg + IW'($countones(a_vld));
    // Head jumps to the oldest live entry so a wrapping tail never looks older
    head_next = tail_next;
    for (int k = N - 1; k >= 0; k--) begin
      if (vld_next[head_reg + IW'(k)]) head_next = head_reg + IW'(k);
    end
    alloc_ready_next = 1'b1;
    for (int j = 0; j < R; j++) begin
      if (vld_next[tail_next + IW'(j)]) alloc_ready_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      head_reg <= '0;
      tail_reg <= '0;
      alloc_ready_reg <= 1'b0;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      alloc_ready_reg <= alloc_ready_next;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      e_vld_reg <= '0;
      e_tag_reg <= '0;
      e_cls_reg <= '0;
      e_dom_reg <= '0;
      e_lat_reg <= '0;
    end else begin
      e_vld_reg <= vld_next;
      for (int i = 0; i < N; i++) begin
        if (a_vld[i]) begin
          e_tag_reg[i] <= in_tag[a_src[i]];
          e_cls_reg[i] <= in_cls[a_src[i]];
          e_dom_reg[i] <= in_dom[a_src[i]];
          e_lat_reg[i] <= in_lat[a_src[i]];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_rdy_reg <= '0;
      s_tag_reg <= '0;
      s_cnt_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        for (int k = 0; k < NS; k++) begin
          if (a_vld[i]) begin
            s_rdy_reg[i][k] <= in_src_rdy[a_src[i]][k];
            s_tag_reg[i][k] <= in_src_tag[a_src[i]][k];
            s_cnt_reg[i][k] <= wk[i][k][3:0];
          end else if (s_fresh[i][k]) begin
            s_rdy_reg[i][k] <= 1'b1;
            s_cnt_reg[i][k] <= 4'h0;
          end else if (s_cnt_reg[i][k] > 4'h1) begin
            s_cnt_reg[i][k] <= s_cnt_reg[i][k] - 4'h1;
          end else if (wk[i][k][6]) begin
            s_cnt_reg[i][k] <= wk[i][k][3:0];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      iss_valid_reg <= '0;
      iss_tag_reg <= '0;
      iss_byp_reg <= '0;
      xfer_valid_reg <= 2'h0;
    end else begin
      xfer_valid_reg <= xfer_next;
      for (int p = 0; p < P; p++) begin
        iss_valid_reg[p] <= sel_vld[p];
        iss_tag_reg[p] <= e_tag_reg[sel_idx[p]];
        iss_byp_reg[p] <= sel_vld[p] ? s_fresh[sel_idx[p]] : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_one_per_port: assert property ($countones(issued) == $countones(sel_vld))
    else $error("one entry issued on two ports");
  a_xfer_blocks_port: assert property (xfer_valid_reg[0] |-> !sel_vld[0] ##1 !iss_valid_reg[0])
    else $error("port 0 issued under a transfer");
  a_xfer5_blocks: assert property (xfer_valid_reg[1] |=> !iss_valid_reg[5])
    else $error("port 5 issued under a transfer");
  for (genvar p = 0; p < P; p++) begin : g_chk
    a_route_legal: assert property (sel_vld[p] |-> |(port_mask(e_cls_reg[sel_idx[p]],
      e_dom_reg[sel_idx[p]]) & (P'(1) << p)) && e_rdy[sel_idx[p]])
      else $error("micro-op sent to a port that cannot serve it");
    a_pick_oldest: assert property (sel_vld[p] |-> req[p][sel_idx[p]]
      && ((((req[p] >> head_reg) | (req[p] << (N - int'(head_reg))))
        & ((N'(1) << IW'(sel_idx[p] - head_reg)) - N'(1))) == '0))
      else $error("older requester passed over");
    a_entry_retired: assert property (sel_vld[p] |=> !e_vld_reg[$past(sel_idx[p])]
      && iss_tag_reg[p] == $past(e_tag_reg[sel_idx[p]]))
      else $error("issued entry still resident");
  end

  c_six_issue: cover property (&sel_vld);
  c_xfer_both: cover property (xfer_valid_reg == 2'h3);
  c_bus_stall: cover property (e_rdy[head_reg] && !issued[head_reg] && e_vld_reg[head_reg]);
  c_bypass: cover property (|iss_byp_reg);
endmodule

// file: sim/udws_rename_model.sv
// Rename-stage model that feeds micro-ops into the scheduler
`timescale 1ns/1ps
module udws_rename_model #(
  parameter int TW = 6
) (
  input wire logic clk_sys,
  input wire logic alloc_ready_reg,
  output logic [3:0] in_valid,
  output logic [3:0][TW-1:0] in_tag,
  output logic [3:0][4:0] in_cls,
  output logic [3:0][1:0] in_dom,
  output logic [3:0][2:0] in_lat,
  output logic [3:0][1:0][TW-1:0] in_src_tag,
  output logic [3:0][1:0] in_src_rdy
);
  typedef struct packed {
    logic [TW-1:0] tag;
    logic [4:0] cls;
    logic [1:0] dom;
    logic [2:0] lat;
    logic [TW-1:0] src;
    logic rdy;
  } udws_uop_t;
  udws_uop_t q[$];
  int shown = 0;
  logic took = 1'b0;
  logic junk = 1'b0;
  task automatic push(input udws_uop_t u);
    q.push_back(u);
  endtask
  // ----------------------------------------
  // Delivery
  // ----------------------------------------
  // Alloc-ready is stable from here to the next rising edge, so it tells whether the slots shown now get taken
  always @(negedge clk_sys) begin
    if (took) begin
      repeat (shown) void'(q.pop_front());
    end
    junk = ~junk;
    shown = (q.size() > 4) ? 4 : q.size();
    took = alloc_ready_reg;
    for (int j = 0; j < 4; j++) begin
      in_valid[j] = (j < shown);
      if (j < shown) begin
        {in_tag[j], in_cls[j], in_dom[j], in_lat[j], in_src_tag[j][0], in_src_rdy[j][0]} = q[j];
        in_src_tag[j][1] = junk ? '1 : '0;
        in_src_rdy[j][1] = 1'b1;
      end else begin
        // Idle slots carry a moving pattern so stale fields cannot pass as valid
        {in_tag[j], in_cls[j], in_dom[j], in_lat[j], in_src_tag[j], in_src_rdy[j]} = junk ? '1 : '0;
      end
    end
  end
endmodule

// file: sim/test_uop_dispatch_writeback_scheduler.sv
// Self-checking bench for the dispatch and writeback scheduler
`timescale 1ns/1ps
module test_uop_dispatch_writeback_scheduler;
  logic clk_sys;
  logic nrst;
  logic [3:0] in_valid;
  logic [3:0][5:0] in_tag;
  logic [3:0][4:0] in_cls;
  logic [3:0][1:0] in_dom;
  logic [3:0][2:0] in_lat;
  logic [3:0][1:0][5:0] in_src_tag;
  logic [3:0][1:0] in_src_rdy;
  logic alloc_ready_reg;
  logic [5:0] iss_valid_reg;
  logic [5:0][5:0] iss_tag_reg;
  logic [5:0][1:0] iss_byp_reg;
  logic [1:0] xfer_valid_reg;
  logic [5:0][2:0] wb_valid_reg;
  logic [5:0][2:0][5:0] wb_tag_reg;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [5:0] nt = 6'h01;
  int ic[64];
  int ip[64];
  int wc[64];
  int wp[64];
  int ws[64];
  logic [1:0] ib[64];
  int xc[2];
  udws_scheduler #(.N(16), .TW(6)) u_udws_scheduler (.clk_sys, .nrst, .in_valid, .in_tag, .in_cls, .in_dom,
    .in_lat, .in_src_tag, .in_src_rdy, .alloc_ready_reg, .iss_valid_reg, .iss_tag_reg, .iss_byp_reg,
    .xfer_valid_reg, .wb_valid_reg, .wb_tag_reg);
  udws_rename_model #(.TW(6)) u_udws_rename_model (.clk_sys, .alloc_ready_reg, .in_valid, .in_tag, .in_cls,
    .in_dom, .in_lat, .in_src_tag, .in_src_rdy);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Monitor and helpers
  // ----------------------------------------
  always @(negedge clk_sys) begin
    cyc++;
    for (int p = 0; p < 6; p++) begin
      if (iss_valid_reg[p] === 1'b1) begin
        ic[iss_tag_reg[p]] = cyc;
        ip[iss_tag_reg[p]] = p;
        ib[iss_tag_reg[p]] = iss_byp_reg[p];
      end
      for (int s = 0; s < 3; s++) begin
        if (wb_valid_reg[p][s] === 1'b1) begin
          wc[wb_tag_reg[p][s]] = cyc;
          wp[wb_tag_reg[p][s]] = p;
          ws[wb_tag_reg[p][s]] = s;
        end
      end
    end
    for (int b = 0; b < 2; b++) begin
      if (xfer_valid_reg[b] === 1'b1) begin
        xc[b] = cyc;
      end
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [4:0] c, input logic [1:0] d, input logic [2:0] l, input logic [5:0] s,
                    input logic r, output logic [5:0] t);
    t = nt;
    nt++;
    u_udws_rename_model.push({t, c, d, l, s, r});
  endtask
  // Bounded wait for an issue, then time for its writeback to land
  task automatic wt(input logic [5:0] t);
    int k = 0;
    while (ic[t] < 0 && k < 80) begin
      @(negedge clk_sys);
      k++;
    end
    if (ic[t] < 0) begin
      errors++;
      stop_test();
    end else begin
      repeat (10) @(negedge clk_sys);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_basic();
    logic [5:0] a;
    op(udws_pkg::CLS_ALU, 2'h0, 3'h1, 6'h00, 1'b1, a);
    wt(a);
    chk(ip[a], 0);
    chk(ib[a], 0);
    chk(wc[a] - ic[a], 1);
    chk(ws[a], 0);
    $display("basic done");
  endtask
  task automatic t_ports();
    logic [5:0] a;
    logic [4:0] c[16] = '{udws_pkg::CLS_MUL, udws_pkg::CLS_SHIFT, udws_pkg::CLS_STR_CMP, udws_pkg::CLS_DIV,
      udws_pkg::CLS_MOV128, udws_pkg::CLS_SHUF, udws_pkg::CLS_BLEND, udws_pkg::CLS_BLEND, udws_pkg::CLS_MOV256,
      udws_pkg::CLS_ADD, udws_pkg::CLS_CVT, udws_pkg::CLS_SHUF, udws_pkg::CLS_DIV, udws_pkg::CLS_ADDR_SLOW,
      udws_pkg::CLS_ADDR_FAST, udws_pkg::CLS_ST_ADDR};
    logic [1:0] d[16] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 3, 0, 0, 0};
    logic [5:0] m[16] = '{6'h01, 6'h21, 6'h01, 6'h01, 6'h23, 6'h22, 6'h22, 6'h21, 6'h21, 6'h02, 6'h02, 6'h20,
      6'h01, 6'h02, 6'h22, 6'h0c};
    for (int i = 0; i < 16; i++) begin
      op(c[i], d[i], 3'h1, 6'h00, 1'b1, a);
      wt(a);
      chk(m[i][ip[a]], 1);
    end
    $display("ports done");
  endtask
  task automatic t_six();
    logic [5:0] t[6];
    logic [5:0] used = '0;
    op(udws_pkg::CLS_MUL, 2'h0, 3'h1, 6'h00, 1'b1, t[0]);
    op(udws_pkg::CLS_LD_ADDR, 2'h0, 3'h4, 6'h00, 1'b1, t[1]);
    op(udws_pkg::CLS_LD_ADDR, 2'h0, 3'h4, 6'h00, 1'b1, t[2]);
    op(udws_pkg::CLS_BRANCH, 2'h0, 3'h1, 6'h00, 1'b1, t[3]);
    op(udws_pkg::CLS_ST_DATA, 2'h0, 3'h1, 6'h00, 1'b1, t[4]);
    op(udws_pkg::CLS_ALU, 2'h0, 3'h1, 6'h00, 1'b1, t[5]);
    for (int i = 0; i < 6; i++) begin
      wt(t[i]);
      used[ip[t[i]]] = 1'b1;
    end
    chk(used, 6'h3f);
    chk(wc[t[1]] - ic[t[1]], 4);
    chk(wc[t[3]], -1);
    $display("six ports done");
  endtask
  task automatic t_clash();
    logic [5:0] a;
    logic [5:0] b;
    logic [5:0] m;
    logic [5:0] d;
    op(udws_pkg::CLS_MUL, 2'h1, 3'h5, 6'h00, 1'b1, a);
    op(udws_pkg::CLS_STR_CMP, 2'h1, 3'h4, 6'h00, 1'b1, b);
    wt(b);
    chk(ic[b] - ic[a], 2);
    chk(wc[b] - wc[a], 1);
    chk(wp[a], ip[a]);
    op(udws_pkg::CLS_MUL, 2'h1, 3'h5, 6'h00, 1'b1, a);
    op(udws_pkg::CLS_MUL, 2'h0, 3'h1, 6'h00, 1'b1, m);
    op(udws_pkg::CLS_BRANCH, 2'h0, 3'h1, 6'h00, 1'b1, b);
    op(udws_pkg::CLS_ALU, 2'h0, 3'h4, 6'h00, 1'b1, d);
    wt(d);
    chk(ic[d] - ic[a], 1);
    chk(wc[d], wc[a]);
    $display("clash done");
  endtask
  task automatic t_age();
    logic [5:0] x;
    logic [5:0] y;
    logic [5:0] z;
    op(udws_pkg::CLS_MUL, 2'h0, 3'h1, 6'h00, 1'b1, x);
    op(udws_pkg::CLS_MUL, 2'h0, 3'h1, 6'h00, 1'b1, y);
    op(udws_pkg::CLS_ALU, 2'h0, 3'h1, y, 1'b0, z);
    wt(z);
    chk(ic[y] - ic[x], 1);
    chk(ic[z] - ic[y], 1);
    chk(ib[z], 2'h1);
    $display("age done");
  endtask
  task automatic t_cross();
    logic [5:0] p;
    logic [5:0] q;
    logic [4:0] pc[10] = '{0, 0, 0, 0, 0, 14, 6, 6, 6, 14};
    logic [1:0] pd[10] = '{0, 0, 1, 1, 1, 2, 0, 1, 3, 3};
    logic [4:0] cc[10] = '{0, 14, 0, 14, 14, 14, 0, 0, 14, 0};
    logic [1:0] cd[10] = '{1, 3, 0, 2, 3, 3, 0, 1, 3, 0};
    int df[10] = '{2, 3, 2, 2, 1, 3, 4, 5, 6, 3};
    logic [1:0] xm[10] = '{1, 1, 2, 0, 0, 2, 0, 0, 0, 2};
    for (int i = 0; i < 10; i++) begin
      op(pc[i], pd[i], (pc[i] == 5'h06) ? 3'h4 : 3'h1, 6'h00, 1'b1, p);
      op(cc[i], cd[i], 3'h1, p, 1'b0, q);
      wt(q);
      chk(ic[q] - ic[p], df[i]);
      chk(ws[p], (pd[i] == 2'h0) ? 0 : (pd[i] == 2'h3) ? 2 : 1);
      if (xm[i][0]) chk(xc[0], ic[p]);
      if (xm[i][1]) chk(xc[1], ic[p]);
    end
    $display("cross done");
  endtask
  initial begin
    foreach (ic[i]) begin
      ic[i] = -1;
      wc[i] = -1;
    end
    nrst = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(alloc_ready_reg, 1'b0);
    nrst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(alloc_ready_reg, 1'b1);
    t_basic();
    t_ports();
    t_six();
    t_clash();
    t_age();
    t_cross();
    stop_test();
  end
endmodule
